// ---- logic/sbp_host.sv ----
// Purpose: processor end of the synchronous host bus port
// Assumes: user commands held until taken; mode_b static between commands
// Notes:   select, strobe and enables move only on the bus rate enable; address, direction, write data load at command take
//
// What this block does
// - variant a: 8-bit address, ready, clocked sampling
// - variant a bus clock at most 50 MHz
// - read: direction high, select with stable address
// - read time varies; wait ready or longer
// - write: direction low, select, strobe, valid data
// - variant a: hold strobe until ready asserts
// - variant b: 18-bit address, buffer enable, acknowledge
// - variant b bus clock at most 70 MHz
// - variant b read: buffer enable held until acknowledge
// - acknowledge only when read data driven
// - release after capture; strobe high during read
// - variant b: use acknowledge or longer waits
// - variant b write: direction, select, strobe order
// - hold strobe to acknowledge; buffer enable high
`timescale 1ns/1ps
`default_nettype none
module sbp_host (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// host bus pins
	sbp_if.host              bus,
	// configuration
	input  wire logic        mode_b,
	input  wire logic        fixed_wait_en,
	// command
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [17:0] cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic             cmd_ready,
	// response
	output logic             rsp_valid,
	output logic [7:0]       rsp_rdata
);
	sbp_pkg::sbp_host_st_t st_ff, nxt_st;
	logic [3:0]            div_ff, nxt_div;
	logic [3:0]            wcnt_ff, nxt_wcnt;
	logic                  wr_ff, nxt_wr;
	logic                  cs_n_ff, nxt_cs_n;
	logic                  rw_ff, nxt_rw;
	logic                  we_n_ff, nxt_we_n;
	logic                  data_buffer_enable_n_n_ff, nxt_data_buffer_enable_n_n;
	logic [17:0]           addr_ff, nxt_addr;
	logic [7:0]            dout_ff, nxt_dout;
	logic                  doe_ff, nxt_doe;
	logic                  rdy_ff, nxt_rdy;
	logic                  rsp_ff, nxt_rsp;
	logic [7:0]            rdata_ff, nxt_rdata;

	// bus rate enable, a tick every div clocks
	wire [3:0] div_w   = mode_b ? sbp_pkg::DIV_B : sbp_pkg::DIV_A;
	wire       tick    = (div_ff == div_w - 4'h1);
	// completion decode
	wire       ack_w   = mode_b ? ~bus.transfer_ack_n : ~bus.rdy_n;
	wire       idle_w  = bus.transfer_ack_n & bus.rdy_n;
	wire       fwait_w = (wcnt_ff == sbp_pkg::FIXED_WAIT);
	wire       done_w  = fixed_wait_en ? fwait_w : ack_w;
	wire       take_w  = cmd_valid & rdy_ff;
	wire [17:0] addr_w = mode_b ? cmd_addr : {10'h000, cmd_addr[7:0]};

	always_comb begin
		nxt_div    = tick ? 4'h0 : div_ff + 4'h1;
		nxt_st     = st_ff;
		nxt_wcnt   = wcnt_ff;
		nxt_wr     = wr_ff;
		nxt_cs_n   = cs_n_ff;
		nxt_rw     = rw_ff;
		nxt_we_n   = we_n_ff;
		nxt_data_buffer_enable_n_n = data_buffer_enable_n_n_ff;
		nxt_addr   = addr_ff;
		nxt_dout   = dout_ff;
		nxt_doe    = doe_ff;
		nxt_rdy    = rdy_ff;
		nxt_rsp    = 1'b0;
		nxt_rdata  = rdata_ff;
		case (st_ff)
			sbp_pkg::HS_IDLE: begin
				if (take_w) begin
					nxt_rdy  = 1'b0;
					nxt_wr   = cmd_write;
					nxt_addr = addr_w;
					nxt_rw   = ~cmd_write;
					nxt_dout = cmd_wdata;
					nxt_st   = sbp_pkg::HS_ADDR;
				end else begin
					nxt_rdy  = 1'b1;
				end
			end
			sbp_pkg::HS_ADDR: begin
				if (tick) begin
					nxt_cs_n = 1'b0;
					nxt_doe  = wr_ff;
					nxt_st   = sbp_pkg::HS_SEL;
				end
			end
			sbp_pkg::HS_SEL: begin
				if (tick) begin
					nxt_we_n   = ~wr_ff;
					nxt_data_buffer_enable_n_n = ~(mode_b & ~wr_ff);
					nxt_wcnt   = 4'h0;
					nxt_st     = sbp_pkg::HS_WAIT;
				end
			end
			sbp_pkg::HS_WAIT: begin
				if (tick) begin
					if (done_w) begin
						nxt_rdata  = bus.data;
						nxt_rsp    = 1'b1;
						nxt_cs_n   = 1'b1;
						nxt_we_n   = 1'b1;
						nxt_data_buffer_enable_n_n = 1'b1;
						nxt_doe    = 1'b0;
						nxt_st     = sbp_pkg::HS_DONE;
					end else if (!fwait_w) begin
						nxt_wcnt = wcnt_ff + 4'h1;
					end
				end
			end
			sbp_pkg::HS_DONE: begin
				if (tick && idle_w) begin
					nxt_rdy = 1'b1;
					nxt_st  = sbp_pkg::HS_IDLE;
				end
			end
			default: begin
				nxt_st = sbp_pkg::HS_IDLE;
			end
		endcase
	end

	// sequencer, rate divider and wait counter
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff   <= sbp_pkg::HS_IDLE;
			div_ff  <= 4'h0;
			wcnt_ff <= 4'h0;
			wr_ff   <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			div_ff  <= nxt_div;
			wcnt_ff <= nxt_wcnt;
			wr_ff   <= nxt_wr;
		end
	end

	// bus control pins
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cs_n_ff   <= 1'b1;
			rw_ff     <= 1'b1;
			we_n_ff   <= 1'b1;
			data_buffer_enable_n_n_ff <= 1'b1;
		end else begin
			cs_n_ff   <= nxt_cs_n;
			rw_ff     <= nxt_rw;
			we_n_ff   <= nxt_we_n;
			data_buffer_enable_n_n_ff <= nxt_data_buffer_enable_n_n;
		end
	end

	// address and write data pins
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			addr_ff <= 18'h00000;
			dout_ff <= sbp_pkg::DATA_RST;
			doe_ff  <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			dout_ff <= nxt_dout;
			doe_ff  <= nxt_doe;
		end
	end

	// user side handshake and read data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdy_ff   <= 1'b0;
			rsp_ff   <= 1'b0;
			rdata_ff <= sbp_pkg::DATA_RST;
		end else begin
			rdy_ff   <= nxt_rdy;
			rsp_ff   <= nxt_rsp;
			rdata_ff <= nxt_rdata;
		end
	end

	// pins and user outputs straight from flops
	assign bus.cs_n                 = cs_n_ff;
	assign bus.rw                   = rw_ff;
	assign bus.we_n                 = we_n_ff;
	assign bus.data_buffer_enable_n = data_buffer_enable_n_n_ff;
	assign bus.addr                 = addr_ff;
	assign bus.host_dout            = dout_ff;
	assign bus.host_doe             = doe_ff;
	assign cmd_ready                = rdy_ff;
	assign rsp_valid                = rsp_ff;
	assign rsp_rdata                = rdata_ff;
endmodule : sbp_host
`default_nettype wire

// ---- logic/sbp_pkg.sv ----
// Purpose: shared constants and types of the synchronous host bus port
// Assumes: one 100 MHz clock; bus rates made by enable pulses
// Notes:   variant a uses addr[7:0] and ready; variant b addr[17:0] and acknowledge
package sbp_pkg;
	// clock and bus rate limits
	localparam int         CLK_MHZ    = 100;
	localparam int         A_MAX_MHZ  = 50;
	localparam int         B_MAX_MHZ  = 70;
	localparam logic [3:0] DIV_A      = 4'((CLK_MHZ + A_MAX_MHZ - 1) / A_MAX_MHZ);
	localparam logic [3:0] DIV_B      = 4'((CLK_MHZ + B_MAX_MHZ - 1) / B_MAX_MHZ);
	// widths
	localparam int         ADDR_W     = 18;
	localparam int         ADDR_A_W   = 8;
	localparam int         DATA_W     = 8;
	localparam int         REG_DEPTH  = 256;
	// device access latency in clocks, by register group
	localparam logic [3:0] LAT_CHAN   = 4'h2;
	localparam logic [3:0] LAT_GLOB   = 4'h5;
	localparam int         GLOB_BIT   = 7;
	// host fixed wait in bus ticks, longer than the slowest access
	localparam logic [3:0] FIXED_WAIT = 4'hA;
	// reset and idle values
	localparam logic [7:0] DATA_RST   = 8'h00;
	localparam logic [7:0] IDLE_BUS   = 8'hFF;

	typedef enum logic [1:0] {
		DV_IDLE = 2'b00,
		DV_WAIT = 2'b01,
		DV_ACK  = 2'b10
	} sbp_dev_st_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_ADDR = 3'b001,
		HS_SEL  = 3'b010,
		HS_WAIT = 3'b011,
		HS_DONE = 3'b100
	} sbp_host_st_t;
endpackage : sbp_pkg

// ---- logic/sbp_if.sv ----
// Purpose: pins between processor and device port
// Assumes: data bus resolved here from the two output enables
// Notes:   undriven data reads as all ones
`timescale 1ns/1ps
`default_nettype none
interface sbp_if;
	logic        cs_n;
	logic        rw;
	logic        we_n;
	logic        data_buffer_enable_n;
	logic [17:0] addr;
	logic [7:0]  host_dout;
	logic        host_doe;
	logic [7:0]  dev_dout;
	logic        dev_doe;
	logic        rdy_n;
	logic        transfer_ack_n;
	wire  [7:0]  data;

	// bus level from the enables
	assign data = dev_doe ? dev_dout : (host_doe ? host_dout : sbp_pkg::IDLE_BUS);

	modport dev (
		input  cs_n, rw, we_n, data_buffer_enable_n, addr, data,
		output dev_dout, dev_doe, rdy_n, transfer_ack_n
	);
	modport host (
		input  data, rdy_n, transfer_ack_n,
		output cs_n, rw, we_n, data_buffer_enable_n, addr, host_dout, host_doe
	);
endinterface : sbp_if
`default_nettype wire

// ---- logic/sbp_device.sv ----
// Purpose: device end of the synchronous host bus port with its register store
// Assumes: pin inputs synchronous to clock; mode_b static between accesses
// Notes:   register store indexed by addr[7:0]
`timescale 1ns/1ps
`default_nettype none
module sbp_device (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// host bus pins
	sbp_if.dev              bus,
	// user side
	input  wire logic       mode_b,
	output logic            upd_valid,
	output logic [7:0]      upd_addr,
	output logic [7:0]      upd_data
);
	logic [7:0]          regs_mem [0:sbp_pkg::REG_DEPTH-1];
	sbp_pkg::sbp_dev_st_t st_ff, nxt_st;
	logic [3:0]          cnt_ff, nxt_cnt;
	logic [7:0]          idx_ff, nxt_idx;
	logic [7:0]          wd_ff, nxt_wd;
	logic                wr_ff, nxt_wr;
	logic                rdy_n_ff, nxt_rdy_n;
	logic                ta_n_ff, nxt_ta_n;
	logic                doe_ff, nxt_doe;
	logic [7:0]          dout_ff, nxt_dout;
	logic                upd_ff, nxt_upd;

	function automatic logic [3:0] sbp_lat(input logic [7:0] a);
		return a[sbp_pkg::GLOB_BIT] ? sbp_pkg::LAT_GLOB : sbp_pkg::LAT_CHAN;
	endfunction : sbp_lat

	// request decode, every input taken at the clock edge
	wire sel_w    = ~bus.cs_n;
	wire rd_qual  = mode_b ? (~bus.data_buffer_enable_n & bus.we_n) : 1'b1;
	wire wr_qual  = mode_b ? bus.data_buffer_enable_n : 1'b1;
	wire rd_req   = sel_w & bus.rw & rd_qual;
	wire wr_req   = sel_w & ~bus.rw & ~bus.we_n & wr_qual;
	wire released = bus.cs_n & bus.we_n;
	wire [7:0] a_w = bus.addr[sbp_pkg::ADDR_A_W-1:0];

	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_idx   = idx_ff;
		nxt_wd    = wd_ff;
		nxt_wr    = wr_ff;
		nxt_rdy_n = rdy_n_ff;
		nxt_ta_n  = ta_n_ff;
		nxt_doe   = doe_ff;
		nxt_dout  = dout_ff;
		nxt_upd   = 1'b0;
		case (st_ff)
			sbp_pkg::DV_IDLE: begin
				if (rd_req | wr_req) begin
					nxt_idx = a_w;
					nxt_wd  = bus.data;
					nxt_wr  = wr_req;
					nxt_cnt = sbp_lat(a_w);
					nxt_st  = sbp_pkg::DV_WAIT;
				end
			end
			sbp_pkg::DV_WAIT: begin
				if (bus.cs_n) begin
					nxt_st = sbp_pkg::DV_IDLE;
				end else if (cnt_ff == 4'h1) begin
					nxt_upd   = wr_ff;
					nxt_dout  = regs_mem[idx_ff];
					nxt_doe   = ~wr_ff;
					nxt_rdy_n = mode_b;
					nxt_ta_n  = ~mode_b;
					nxt_st    = sbp_pkg::DV_ACK;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			sbp_pkg::DV_ACK: begin
				if (released) begin
					nxt_rdy_n = 1'b1;
					nxt_ta_n  = 1'b1;
					nxt_doe   = 1'b0;
					nxt_st    = sbp_pkg::DV_IDLE;
				end
			end
			default: begin
				nxt_st = sbp_pkg::DV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff    <= sbp_pkg::DV_IDLE;
			cnt_ff   <= 4'h0;
			idx_ff   <= 8'h00;
			wd_ff    <= sbp_pkg::DATA_RST;
			wr_ff    <= 1'b0;
			rdy_n_ff <= 1'b1;
			ta_n_ff  <= 1'b1;
			doe_ff   <= 1'b0;
			dout_ff  <= sbp_pkg::DATA_RST;
			upd_ff   <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			idx_ff   <= nxt_idx;
			wd_ff    <= nxt_wd;
			wr_ff    <= nxt_wr;
			rdy_n_ff <= nxt_rdy_n;
			ta_n_ff  <= nxt_ta_n;
			doe_ff   <= nxt_doe;
			dout_ff  <= nxt_dout;
			upd_ff   <= nxt_upd;
		end
	end

	// register store, written when the acknowledge goes out
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < sbp_pkg::REG_DEPTH; i++) begin
				regs_mem[i] <= sbp_pkg::DATA_RST;
			end
		end else if (nxt_upd) begin
			regs_mem[idx_ff] <= wd_ff;
		end
	end

	assign bus.rdy_n          = rdy_n_ff;
	assign bus.transfer_ack_n = ta_n_ff;
	assign bus.dev_doe        = doe_ff;
	assign bus.dev_dout       = dout_ff;
	assign upd_valid          = upd_ff;
	assign upd_addr           = idx_ff;
	assign upd_data           = wd_ff;
endmodule : sbp_device
`default_nettype wire

// ---- bench/sbp_properties.sv ----
// Purpose: pin rule checks for the port
// Assumes: one clock, reset high
// Notes:   ack means rdy_n or transfer_ack_n low
`timescale 1ns/1ps
`default_nettype none
module sbp_properties (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// bus pins
	input  wire logic        cs_n,
	input  wire logic        rw,
	input  wire logic        we_n,
	input  wire logic        data_buffer_enable_n,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  data,
	input  wire logic        dev_doe,
	input  wire logic        rdy_n,
	input  wire logic        transfer_ack_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire ack = !rdy_n || !transfer_ack_n;
	sequence s_sel_start;
		$fell(cs_n);
	endsequence
	sequence s_acked;
		ack;
	endsequence
	a_ack_bounded: assert property (s_sel_start |-> ##[1:40] s_acked)
		else $error("no ack after select");
	a_ack_needs_sel: assert property (s_acked and $rose(ack) |-> !$past(cs_n))
		else $error("ack without select");
	a_ack_holds: assert property (ack && !cs_n |=> $stable({rdy_n, transfer_ack_n}))
		else $error("ack dropped early");
	a_ack_release: assert property (ack && cs_n && we_n |=> !ack && !dev_doe)
		else $error("ack not released");
	a_read_data: assert property (ack && rw |-> dev_doe)
		else $error("ack without read data");
	a_one_ack: assert property (!rdy_n |-> transfer_ack_n)
		else $error("both acks low");
	a_strobe_holds: assert property (!we_n && !ack |=> !we_n)
		else $error("strobe dropped early");
	a_read_we_high: assert property (!cs_n && rw |-> we_n)
		else $error("strobe low in read");
	a_write_data_buffer_enable_n: assert property (!cs_n && !rw |-> data_buffer_enable_n)
		else $error("buffer enable low in write");
	a_sel_setup: assert property (s_sel_start |-> $stable(rw) && $stable(addr))
		else $error("direction or address moved at select");
	a_wdata_stable: assert property (!we_n && !$past(we_n) |-> $stable(data))
		else $error("write data moved");
endmodule : sbp_properties
`default_nettype wire

// ---- bench/sync_host_bus_port_test.sv ----
// Purpose: both ends joined, driven through host commands
// Assumes: 100 MHz clock, reset high for 4 cycles
// Notes:   second bus has a bench driver for an aborted write
`timescale 1ns/1ps
`default_nettype none
`define SBP_CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module sync_host_bus_port_test;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        mode_b = 1'b0;
	logic        fixed_wait_en = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic [17:0] cmd_addr = 18'h00000;
	logic [7:0]  cmd_wdata = 8'h00;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [7:0]  rsp_rdata;
	logic        upd_valid;
	logic [7:0]  upd_addr;
	logic [7:0]  upd_data;
	logic        upd2_valid;
	logic [7:0]  upd2_data;
	logic [7:0]  q;
	logic [7:0]  d;
	int          checks = 0;
	int          fail_count = 0;
	int          upd_cnt = 0;
	int          upd2_cnt = 0;

	always #5 clock = ~clock;
	always @(negedge clock) begin
		upd_cnt += (upd_valid === 1'b1);
		upd2_cnt += (upd2_valid === 1'b1);
	end

	sbp_if i_sbp_if ();
	sbp_if i_sbp_if_2 ();
	sbp_host i_sbp_host (.clock(clock), .sys_rst(sys_rst), .bus(i_sbp_if.host), .mode_b(mode_b),
		.fixed_wait_en(fixed_wait_en), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	sbp_device i_sbp_device (.clock(clock), .sys_rst(sys_rst), .bus(i_sbp_if.dev), .mode_b(mode_b),
		.upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data));
	sbp_device i_sbp_device_2 (.clock(clock), .sys_rst(sys_rst), .bus(i_sbp_if_2.dev), .mode_b(1'b0),
		.upd_valid(upd2_valid), .upd_addr(), .upd_data(upd2_data));
	sbp_properties i_sbp_properties (.clock(clock), .sys_rst(sys_rst), .cs_n(i_sbp_if.cs_n),
		.rw(i_sbp_if.rw), .we_n(i_sbp_if.we_n), .data_buffer_enable_n(i_sbp_if.data_buffer_enable_n),
		.addr(i_sbp_if.addr), .data(i_sbp_if.data), .dev_doe(i_sbp_if.dev_doe), .rdy_n(i_sbp_if.rdy_n),
		.transfer_ack_n(i_sbp_if.transfer_ack_n));

	task wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic wait_for(ref logic sig, input string what);
		int n;
		for (n = 0; n < 60 && sig !== 1'b1; n++)
			@(negedge clock);
		if (n == 60) begin
			fail_count++;
			$display("ERROR %s expected 1 seen timeout", what);
			wrap_up();
		end
	endtask : wait_for

	// one host command, read data left in q
	task xfer(input logic wr, input logic [17:0] a, input logic [7:0] wd);
		@(negedge clock);
		wait_for(cmd_ready, "cmd_ready");
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr <= a;
		cmd_wdata <= wd;
		@(posedge clock);
		cmd_valid <= 1'b0;
		@(negedge clock);
		wait_for(rsp_valid, "rsp_valid");
		q = rsp_rdata;
	endtask : xfer

	// write on the second bus, strobe dropped early when abort is set
	task raw_wr(input logic [7:0] a, input logic [7:0] wd, input logic abort);
		int n;
		@(posedge clock);
		i_sbp_if_2.addr <= {10'h000, a};
		i_sbp_if_2.rw <= 1'b0;
		i_sbp_if_2.host_dout <= wd;
		i_sbp_if_2.host_doe <= 1'b1;
		@(posedge clock);
		i_sbp_if_2.cs_n <= 1'b0;
		i_sbp_if_2.we_n <= 1'b0;
		if (!abort) begin
			for (n = 0; n < 60 && i_sbp_if_2.rdy_n !== 1'b0; n++)
				@(negedge clock);
			if (n == 60) begin
				fail_count++;
				$display("ERROR rdy_n expected 0 seen timeout");
				wrap_up();
			end
		end
		@(posedge clock);
		i_sbp_if_2.cs_n <= 1'b1;
		i_sbp_if_2.we_n <= 1'b1;
		i_sbp_if_2.host_doe <= 1'b0;
		repeat (8) @(posedge clock);
	endtask : raw_wr

	initial begin
		i_sbp_if_2.cs_n = 1'b1;
		i_sbp_if_2.rw = 1'b1;
		i_sbp_if_2.we_n = 1'b1;
		i_sbp_if_2.data_buffer_enable_n = 1'b1;
		i_sbp_if_2.addr = 18'h00000;
		i_sbp_if_2.host_dout = 8'h00;
		i_sbp_if_2.host_doe = 1'b0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		xfer(1'b0, 18'h00040, 8'h00);
		`SBP_CHECK("reset read", 8'h00, q)
		for (int cfg = 0; cfg < 4; cfg++) begin
			@(posedge clock);
			mode_b <= cfg[1];
			fixed_wait_en <= cfg[0];
			d = 8'h30 + 8'(cfg);
			xfer(1'b1, 18'h2A505, d);
			`SBP_CHECK("upd_addr", 8'h05, upd_addr)
			`SBP_CHECK("upd_data", d, upd_data)
			xfer(1'b1, 18'h00083, ~d);
			`SBP_CHECK("upd_data", ~d, upd_data)
			xfer(1'b0, 18'h00005, 8'h00);
			`SBP_CHECK("read chan", d, q)
			xfer(1'b0, 18'h10083, 8'h00);
			`SBP_CHECK("read glob", ~d, q)
		end
		`SBP_CHECK("write count", 8, upd_cnt)
		raw_wr(8'h87, 8'hC3, 1'b1);
		`SBP_CHECK("aborted write", 0, upd2_cnt)
		raw_wr(8'h87, 8'hC3, 1'b0);
		`SBP_CHECK("held write", 1, upd2_cnt)
		`SBP_CHECK("held data", 8'hC3, upd2_data)
		wrap_up();
	end
endmodule : sync_host_bus_port_test
`default_nettype wire
